/* File: hdl/can_msg_buffering.sv */
// CAN message buffering: receive buffers, transmit queue, error counters
`include "can_buf_map.svh"
module can_msg_buffering
  import can_buf_pkg::*;
(
  input wire logic sys_clk_in,                 // 10 MHz module clock
  input wire logic rst_n_in,                   // Async reset, active low
  input wire logic init_mode_in,               // Initialization mode level
  input wire logic rx_frame_done_in,           // Engine: valid frame at EOF
  input wire logic rx_error_in,                // Engine: crc/stuff/form error
  input wire frame_t assembly_buffer_in,       // Engine: assembled frame
  input wire filter_bank_t filter_id_in,       // Filter identifiers
  input wire logic [5:0] filter_extended_select_in, // Filter format select
  input wire logic [`CB_ID_W-1:0] mask_zero_in, // Mask for buffer zero
  input wire logic [`CB_ID_W-1:0] mask_one_in,  // Mask for buffer one
  input wire logic [3:0] receive_mode_field_in, // Modes, [1:0] buffer zero
  input wire logic double_buffer_enable_in,    // Spill zero into one
  input wire logic [1:0] receive_irq_enable_in, // Receive irq enables
  input wire logic [1:0] rx_done_clear_in,     // Release receive buffer
  input wire logic [1:0] overrun_clear_in,     // Clear overrun flags
  input wire logic error_clear_in,             // Clear summary error flag
  input wire logic invalid_clear_in,           // Clear invalid-message flag
  input wire logic rx_read_sel_in,             // Receive buffer to read
  input wire logic tx_write_in,                // Load transmit buffer
  input wire logic [1:0] tx_write_sel_in,      // Transmit buffer to load
  input wire tx_image_t tx_write_data_in,      // Fourteen-byte image
  input wire logic [2:0] request_set_in,       // Set transmit request
  input wire logic [2:0] request_clear_in,     // Clear request (abort)
  input wire logic abort_all_bit_in,           // Abort all pending
  input wire logic [5:0] transmit_priority_field_in, // Two bits per buffer
  input wire logic [2:0] transmit_irq_enable_in, // Transmit irq enables
  input wire logic tx_start_in,                // Engine: SOF of selection
  input wire logic tx_ok_in,                   // Engine: frame sent
  input wire logic tx_arb_lost_in,             // Engine: arbitration lost
  input wire logic tx_error_in,                // Engine: ack/form/bit error
  output frame_t rx_data_out,                  // Selected receive buffer
  output logic [1:0] receive_done_flag_out,    // Buffer holds a frame
  output logic [1:0] receive_overrun_flag_out, // Overrun per buffer
  output logic summary_error_flag_out,         // Overrun or transmit warning rise
  output logic invalid_message_flag_out,       // Error in last frame
  output logic receive_warning_flag_out,       // Receive counter >= 96
  output logic receive_passive_flag_out,       // Receive counter > 127
  output logic transmit_warning_flag_out,      // Transmit counter > 96
  output logic transmit_passive_flag_out,      // Transmit counter > 127
  output logic bus_off_flag_out,               // Transmit counter > 255
  output logic [7:0] receive_error_counter_out, // Receive error count
  output logic [8:0] transmit_error_counter_out, // Transmit error count
  output logic [2:0] transmit_request_bit_out, // Pending per buffer
  output logic [2:0] transmit_aborted_flag_out, // Abort done
  output logic [2:0] arbitration_lost_flag_out, // Lost arbitration
  output logic [2:0] transmit_error_flag_out,  // Bus error on attempt
  output logic [2:0] transmit_buffer_free_flag_out, // Buffer emptied
  output logic [1:0] tx_sel_out,               // Buffer to send next
  output logic tx_pending_out,                 // Something to send
  output tx_image_t tx_data_out,               // Image of tx_sel_out
  output logic [1:0] rx_irq_out,               // Receive irq pulse
  output logic tx_irq_out,                     // Transmit irq pulse
  output logic err_irq_out                     // Error irq pulse
);
  logic [1:0] hit;
  logic store_en;
  logic store_sel;
  logic [1:0] ovr_ev;
  logic [1:0] next_sel;
  logic busy;
  logic [1:0] busy_idx;
  logic [2:0] abort_pend;
  logic [2:0] ok_ev;
  logic rx_warn_rise;
  logic tx_warn_rise;

  can_accept_filter u_filter (
    .id_in(assembly_buffer_in.id),
    .frame_extended_marker_in(assembly_buffer_in.ext),
    .frame_ok_in(rx_frame_done_in),
    .frame_err_in(rx_error_in),
    .filter_id_in(filter_id_in),
    .filter_extended_select_in(filter_extended_select_in),
    .mask_zero_in(mask_zero_in),
    .mask_one_in(mask_one_in),
    .mode_zero_in(receive_mode_field_in[1:0]),
    .mode_one_in(receive_mode_field_in[3:2]),
    .hit_out(hit)
  );

  // Buffer zero has precedence when both banks accept the frame
  always_comb
  begin
    store_en = 1'b0;
    store_sel = 1'b0;
    ovr_ev = 2'b00;
    if (hit[0])
    begin
      if (!receive_done_flag_out[0])
        store_en = 1'b1;
      else if (double_buffer_enable_in && !receive_done_flag_out[1])
      begin
        store_en = 1'b1;
        store_sel = 1'b1;
      end
      else if (double_buffer_enable_in)
        ovr_ev[1] = 1'b1;
      else
        ovr_ev[0] = 1'b1;
    end
    else if (hit[1])
    begin
      if (!receive_done_flag_out[1])
      begin
        store_en = 1'b1;
        store_sel = 1'b1;
      end
      else
        ovr_ev[1] = 1'b1;
    end
  end

  // A refused frame is simply never written: the assembly copy is dropped
  can_msg_store #(.WIDTH($bits(frame_t)), .DEPTH(`CB_NUM_RX)) u_rx_store (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(store_en),
    .wr_addr_in(store_sel),
    .wr_data_in(assembly_buffer_in),
    .rd_addr_in(rx_read_sel_in),
    .rd_data_out(rx_data_out)
  );

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      receive_done_flag_out <= 2'b00;
      receive_overrun_flag_out <= 2'b00;
      rx_irq_out <= 2'b00;
    end
    else
    begin
      for (int b = 0; b < `CB_NUM_RX; b++)
      begin
        if (store_en && store_sel == b[0])
          receive_done_flag_out[b] <= 1'b1;
        else if (rx_done_clear_in[b])
          receive_done_flag_out[b] <= 1'b0;
        if (ovr_ev[b])
          receive_overrun_flag_out[b] <= 1'b1;
        else if (overrun_clear_in[b])
          receive_overrun_flag_out[b] <= 1'b0;
        rx_irq_out[b] <= store_en && store_sel == b[0] &&
                         receive_irq_enable_in[b];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      receive_error_counter_out <= 8'h00;
    else if (init_mode_in)
      receive_error_counter_out <= 8'h00;
    else if (rx_error_in &&
             receive_error_counter_out != `CB_RX_CNT_MAX)
      receive_error_counter_out <= receive_error_counter_out + 8'h01;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      transmit_error_counter_out <= 9'h000;
    else if (init_mode_in)
      transmit_error_counter_out <= 9'h000;
    else if (tx_error_in && !bus_off_flag_out &&
             transmit_error_counter_out <= `CB_BUS_OFF_LIMIT)
      transmit_error_counter_out <= transmit_error_counter_out + 9'h001;
  end

  // Level flags track the counters one cycle behind
  assign rx_warn_rise = !receive_warning_flag_out &&
                        receive_error_counter_out >= `CB_RX_WARN_LIMIT;
  assign tx_warn_rise = !transmit_warning_flag_out &&
                        transmit_error_counter_out > `CB_TX_WARN_LIMIT;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      receive_warning_flag_out <= 1'b0;
      receive_passive_flag_out <= 1'b0;
      transmit_warning_flag_out <= 1'b0;
      transmit_passive_flag_out <= 1'b0;
      bus_off_flag_out <= 1'b0;
    end
    else
    begin
      receive_warning_flag_out <=
        receive_error_counter_out >= `CB_RX_WARN_LIMIT;
      receive_passive_flag_out <=
        receive_error_counter_out > 8'(`CB_PASSIVE_LIMIT);
      transmit_warning_flag_out <=
        transmit_error_counter_out > `CB_TX_WARN_LIMIT;
      transmit_passive_flag_out <=
        transmit_error_counter_out > `CB_PASSIVE_LIMIT;
      bus_off_flag_out <=
        transmit_error_counter_out > `CB_BUS_OFF_LIMIT;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      summary_error_flag_out <= 1'b0;
      invalid_message_flag_out <= 1'b0;
      err_irq_out <= 1'b0;
    end
    else
    begin
      if ((|ovr_ev) || tx_warn_rise)
        summary_error_flag_out <= 1'b1;
      else if (error_clear_in)
        summary_error_flag_out <= 1'b0;
      if (rx_error_in)
        invalid_message_flag_out <= 1'b1;
      else if (invalid_clear_in)
        invalid_message_flag_out <= 1'b0;
      // Receive errors alone do not interrupt, only their consequences
      err_irq_out <= (|ovr_ev) || rx_warn_rise || tx_warn_rise;
    end
  end

  // Highest code wins; on a tie the lower-numbered buffer is sent
  always_comb
  begin
    next_sel = 2'd0;
    for (int t = `CB_NUM_TX - 1; t >= 0; t--)
    begin
      if (transmit_request_bit_out[t] &&
          (!transmit_request_bit_out[next_sel] ||
           transmit_priority_field_in[2*t +: 2] >=
           transmit_priority_field_in[2*next_sel +: 2]))
        next_sel = t[1:0];
    end
  end

  // Selection keeps following priority changes until SOF latches it
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_sel_out <= 2'd0;
      tx_pending_out <= 1'b0;
    end
    else
    begin
      tx_sel_out <= next_sel;
      tx_pending_out <= (|transmit_request_bit_out) && !busy &&
                        !bus_off_flag_out && !init_mode_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy <= 1'b0;
      busy_idx <= 2'd0;
    end
    else if (tx_start_in && tx_pending_out)
    begin
      busy <= 1'b1;
      busy_idx <= tx_sel_out;
    end
    else if (tx_ok_in || tx_arb_lost_in || tx_error_in)
      busy <= 1'b0;
  end

  can_msg_store #(.WIDTH($bits(tx_image_t)), .DEPTH(`CB_NUM_TX)) u_tx_store (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(tx_write_in),
    .wr_addr_in(tx_write_sel_in),
    .wr_data_in(tx_write_data_in),
    .rd_addr_in(next_sel),
    .rd_data_out(tx_data_out)
  );

  for (genvar i = 0; i < `CB_NUM_TX; i++)
  begin : g_tx
    wire mine = busy && busy_idx == i;
    wire abort_req = request_clear_in[i] || abort_all_bit_in;
    assign ok_ev[i] = mine && tx_ok_in;

    // An abort on a running frame waits for it to fail or finish
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        transmit_request_bit_out[i] <= 1'b0;
        transmit_aborted_flag_out[i] <= 1'b0;
        arbitration_lost_flag_out[i] <= 1'b0;
        transmit_error_flag_out[i] <= 1'b0;
        transmit_buffer_free_flag_out[i] <= 1'b0;
        abort_pend[i] <= 1'b0;
      end
      else if (request_set_in[i])
      begin
        transmit_request_bit_out[i] <= 1'b1;
        transmit_aborted_flag_out[i] <= 1'b0;
        arbitration_lost_flag_out[i] <= 1'b0;
        transmit_error_flag_out[i] <= 1'b0;
        transmit_buffer_free_flag_out[i] <= 1'b0;
        abort_pend[i] <= 1'b0;
      end
      else if (ok_ev[i])
      begin
        transmit_request_bit_out[i] <= 1'b0;
        transmit_buffer_free_flag_out[i] <= 1'b1;
        abort_pend[i] <= 1'b0;
      end
      else if (mine && (tx_arb_lost_in || tx_error_in))
      begin
        if (tx_error_in)
          transmit_error_flag_out[i] <= 1'b1;
        else
          arbitration_lost_flag_out[i] <= 1'b1;
        if (abort_pend[i] || abort_req)
        begin
          transmit_request_bit_out[i] <= 1'b0;
          transmit_aborted_flag_out[i] <= 1'b1;
        end
        abort_pend[i] <= 1'b0;
      end
      else if (abort_req && transmit_request_bit_out[i])
      begin
        if (mine)
          abort_pend[i] <= 1'b1;
        else
        begin
          transmit_request_bit_out[i] <= 1'b0;
          transmit_aborted_flag_out[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_irq_out <= 1'b0;
    else
      tx_irq_out <= |(ok_ev & transmit_irq_enable_in);
  end

  store_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_frame_done_in && hit[0] && !receive_done_flag_out[0]
    |=> receive_done_flag_out[0] && $stable(receive_done_flag_out[1]))
    else $error("frame for free buffer zero not stored");
  overrun_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_frame_done_in && hit[1] && !hit[0] && receive_done_flag_out[1]
    |=> receive_overrun_flag_out[1] && summary_error_flag_out)
    else $error("overrun on buffer one not flagged");
  no_divert_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !double_buffer_enable_in && hit[0] && receive_done_flag_out[0]
    |=> receive_overrun_flag_out[0] && !$rose(receive_done_flag_out[1]))
    else $error("frame diverted without double buffering");
  spill_one_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    double_buffer_enable_in && hit[0] && receive_done_flag_out[0] &&
    !receive_done_flag_out[1] && !overrun_clear_in[0]
    |=> receive_done_flag_out[1] && $stable(receive_overrun_flag_out[0]))
    else $error("double buffer spill failed");
  rx_warn_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    receive_error_counter_out == 8'h5f && rx_error_in && !init_mode_in
    |=> ##1 receive_warning_flag_out && err_irq_out)
    else $error("receive warning missed at 96");
  rx_passive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    receive_error_counter_out == 8'h80 |=> receive_passive_flag_out)
    else $error("receive passive missed above 127");
  bus_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    transmit_error_counter_out == 9'h100 |=> bus_off_flag_out &&
    transmit_passive_flag_out ##1 !tx_pending_out)
    else $error("bus-off not entered above 255");
  init_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    init_mode_in |=> receive_error_counter_out == 8'h00 &&
    transmit_error_counter_out == 9'h000 &&
    $stable(receive_done_flag_out))
    else $error("init mode did not clear counters");
  sent_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    busy && tx_ok_in && !request_set_in[busy_idx]
    |=> !transmit_request_bit_out[$past(busy_idx)] &&
    transmit_buffer_free_flag_out[$past(busy_idx)])
    else $error("request not cleared after success");
  arb_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    busy && tx_arb_lost_in && !tx_error_in && !abort_pend[busy_idx] &&
    !abort_all_bit_in && !request_clear_in[busy_idx] &&
    !request_set_in[busy_idx]
    |=> transmit_request_bit_out[$past(busy_idx)] &&
    arbitration_lost_flag_out[$past(busy_idx)] && !tx_irq_out)
    else $error("arbitration loss handled wrongly");
endmodule

/* File: hdl/can_buf_map.svh */
// Constants for the CAN message buffering block
`ifndef CAN_BUF_MAP_SVH
`define CAN_BUF_MAP_SVH
`define CB_NUM_FILTERS 6
`define CB_NUM_RX 2
`define CB_NUM_TX 3
`define CB_ID_W 29
`define CB_SID_LSB 18
`define CB_TX_BYTES 14
`define CB_RX_WARN_LIMIT 8'h60
`define CB_PASSIVE_LIMIT 9'h07f
`define CB_TX_WARN_LIMIT 9'h060
`define CB_BUS_OFF_LIMIT 9'h0ff
`define CB_RX_CNT_MAX 8'hff
`define CB_MODE_ALL 2'b00
`define CB_MODE_EXT 2'b01
`define CB_MODE_STD 2'b10
`define CB_MODE_ANY 2'b11
`endif

/* File: hdl/can_buf_pkg.sv */
// Types shared by the CAN message buffering block
`include "can_buf_map.svh"
package can_buf_pkg;
  typedef struct packed
  {
    logic [`CB_ID_W-1:0] id;
    logic ext;
    logic [3:0] dlc;
    logic [63:0] data;
  } frame_t;
  typedef logic [`CB_TX_BYTES*8-1:0] tx_image_t;
  typedef logic [`CB_NUM_FILTERS-1:0][`CB_ID_W-1:0] filter_bank_t;
endpackage

/* File: hdl/can_msg_store.sv */
// Small message memory with a registered read port
module can_msg_store #(
  parameter int WIDTH = 98,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_in,                    // Module clock
  input wire logic wr_en_in,                      // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in, // Write entry
  input wire logic [WIDTH-1:0] wr_data_in,        // Write word
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in, // Read entry
  output logic [WIDTH-1:0] rd_data_out            // Registered read word
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("can_msg_store: unsupported size");
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (wr_en_in)
      mem[wr_addr_in] <= wr_data_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

/* File: hdl/can_accept_filter.sv */
// Acceptance filters and masks steering frames to the two receive buffers
`include "can_buf_map.svh"
module can_accept_filter
  import can_buf_pkg::*;
(
  input wire logic [`CB_ID_W-1:0] id_in,       // Assembled identifier
  input wire logic frame_extended_marker_in,   // Frame is extended format
  input wire logic frame_ok_in,                // Valid frame completed
  input wire logic frame_err_in,               // Reception ended in error
  input wire filter_bank_t filter_id_in,       // Six filter identifiers
  input wire logic [`CB_NUM_FILTERS-1:0] filter_extended_select_in, // Ext sel
  input wire logic [`CB_ID_W-1:0] mask_zero_in, // Mask for buffer zero
  input wire logic [`CB_ID_W-1:0] mask_one_in,  // Mask for buffer one
  input wire logic [1:0] mode_zero_in,         // Receive mode, buffer zero
  input wire logic [1:0] mode_one_in,          // Receive mode, buffer one
  output logic [1:0] hit_out                   // Buffer acceptance
);
  logic [`CB_NUM_FILTERS-1:0] match;

  for (genvar i = 0; i < `CB_NUM_FILTERS; i++)
  begin : g_filt
    // Filters 0 and 1 belong to buffer zero, the rest to buffer one
    wire [1:0] mode = (i < 2) ? mode_zero_in : mode_one_in;
    wire [`CB_ID_W-1:0] mask = (i < 2) ? mask_zero_in : mask_one_in;
    // Receive mode 01/10 overrides the per-filter format selection
    wire want_ext = (mode == `CB_MODE_EXT) ? 1'b1 :
                    (mode == `CB_MODE_STD) ? 1'b0 :
                    filter_extended_select_in[i];
    // Cleared mask bits always count as matching
    wire [`CB_ID_W-1:0] diff = (id_in ^ filter_id_in[i]) & mask;
    wire same = frame_extended_marker_in ? (diff == '0) :
                (diff[`CB_ID_W-1:`CB_SID_LSB] == '0);
    assign match[i] = frame_ok_in &
                      (want_ext == frame_extended_marker_in) & same;
  end

  // Mode 11 takes every frame, even one cut short by an error
  assign hit_out[0] = (|match[1:0]) | ((mode_zero_in == `CB_MODE_ANY) &
                      (frame_ok_in | frame_err_in));
  assign hit_out[1] = (|match[`CB_NUM_FILTERS-1:2]) |
                      ((mode_one_in == `CB_MODE_ANY) &
                      (frame_ok_in | frame_err_in));
endmodule

/* File: sim/can_engine_model.sv */
// Transmit side stand-in for the protocol engine
module can_engine_model (
  input wire logic sys_clk_in,      // Module clock
  input wire logic rst_n_in,        // Reset, active low
  input wire logic pending_in,      // Frame waiting to go
  input wire logic [1:0] result_in, // 0 sent, 1 arb lost, 2 bus error
  output logic start_out,           // Start of frame
  output logic ok_out,              // Frame sent
  output logic arb_out,             // Arbitration lost
  output logic err_out              // Bus error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] busy;
  // Idle gap after each attempt gives the queue time to settle
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      busy <= 3'h0;
    else if (busy == 3'h1 && !pending_in)
      busy <= 3'h0; // Block refused the start, no attempt runs
    else if (busy != 3'h0)
      busy <= busy + 3'h1;
    else if (pending_in)
      busy <= 3'h1;
  end
  assign start_out = (busy == 3'h1);
  assign ok_out = (busy == 3'h4) && (result_in == 2'h0);
  assign arb_out = (busy == 3'h4) && (result_in == 2'h1);
  assign err_out = (busy == 3'h4) && (result_in == 2'h2);
endmodule

/* File: sim/test_can_msg_buffering.sv */
// Self-checking bench for the CAN message buffering block
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
`define WT(c) for (int k = 0; k < 3000 && !(c); k++) tick(1);
module test_can_msg_buffering
  import can_buf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [28:0] ID_A = 29'h00400000;
  localparam logic [28:0] ID_B = 29'h00800000;
  logic sys_clk_in, rst_n_in, init_mode_in, rx_frame_done_in, rx_error_in;
  frame_t assembly_buffer_in, rx_data_out;
  filter_bank_t filter_id_in;
  logic [5:0] filter_extended_select_in, transmit_priority_field_in;
  logic [28:0] mask_zero_in, mask_one_in;
  logic [3:0] receive_mode_field_in;
  logic [1:0] receive_irq_enable_in, rx_done_clear_in, overrun_clear_in;
  logic double_buffer_enable_in, error_clear_in, invalid_clear_in;
  logic rx_read_sel_in, tx_write_in, abort_all_bit_in, tx_start_in;
  logic [1:0] tx_write_sel_in, tx_sel_out, rx_irq_out, result;
  tx_image_t tx_write_data_in, tx_data_out;
  logic [2:0] request_set_in, request_clear_in, transmit_irq_enable_in;
  logic tx_ok_in, tx_arb_lost_in, tx_error_in, summary_error_flag_out;
  logic [1:0] receive_done_flag_out, receive_overrun_flag_out;
  logic invalid_message_flag_out, receive_warning_flag_out, tx_pending_out;
  logic receive_passive_flag_out, transmit_warning_flag_out, tx_irq_out;
  logic transmit_passive_flag_out, bus_off_flag_out, err_irq_out;
  logic [7:0] receive_error_counter_out;
  logic [8:0] transmit_error_counter_out;
  logic [2:0] transmit_request_bit_out, transmit_aborted_flag_out;
  logic [2:0] arbitration_lost_flag_out, transmit_error_flag_out;
  logic [2:0] transmit_buffer_free_flag_out;
  int n_errors = 0;
  int num_checks = 0;
  can_msg_buffering dut (.*);
  can_engine_model engine (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .pending_in(tx_pending_out), .result_in(result), .start_out(tx_start_in),
    .ok_out(tx_ok_in), .arb_out(tx_arb_lost_in), .err_out(tx_error_in));
  always #50 sys_clk_in = ~sys_clk_in;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #10;
  endtask
  task automatic rx(input logic [28:0] id, input logic ext);
    assembly_buffer_in = {id, ext, 4'h8, {35'h0, id}};
    rx_frame_done_in = 1'b1;
    tick(1);
    rx_frame_done_in = 1'b0;
  endtask
  task automatic err(input int n);
    repeat (n)
    begin
      rx_error_in = 1'b1;
      tick(1);
      rx_error_in = 1'b0;
      tick(1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #3000000;
    n_errors++;
    conclude();
  end
  initial
  begin
    {sys_clk_in, rst_n_in, init_mode_in, rx_frame_done_in, rx_error_in,
      filter_extended_select_in, receive_mode_field_in, rx_read_sel_in,
      double_buffer_enable_in, rx_done_clear_in, overrun_clear_in,
      error_clear_in, invalid_clear_in, tx_write_in, tx_write_sel_in,
      request_set_in, request_clear_in, abort_all_bit_in, result} = '0;
    assembly_buffer_in = '0;
    tx_write_data_in = '0;
    filter_id_in = {6{29'h1fffffff}};
    filter_id_in[0] = ID_A;
    filter_id_in[2] = ID_B;
    mask_zero_in = 29'h1fffffff;
    mask_one_in = 29'h1ffc0000;
    receive_irq_enable_in = 2'h3;
    transmit_irq_enable_in = 3'h7;
    transmit_priority_field_in = 6'h2d;
    tick(8);
    rst_n_in = 1'b1;
    `CHK("idle", 5'h00, {receive_done_flag_out, transmit_request_bit_out})
    rx(ID_A, 1'b0);
    `CHK("done", 4'h5, {receive_done_flag_out, rx_irq_out})
    tick(1);
    `CHK("rx id", ID_A, rx_data_out.id)
    rx(ID_A, 1'b0);
    `CHK("overrun", 3'h3, {receive_overrun_flag_out, summary_error_flag_out})
    `CHK("no spill", 2'h1, receive_done_flag_out)
    overrun_clear_in = 2'h3;
    tick(1);
    overrun_clear_in = 2'h0;
    double_buffer_enable_in = 1'b1;
    rx(ID_A, 1'b0);
    `CHK("spill", 4'hc, {receive_done_flag_out, receive_overrun_flag_out})
    rx(ID_A, 1'b0);
    `CHK("both full", 2'h2, receive_overrun_flag_out)
    $display("test receive ended");
    rx_done_clear_in = 2'h3;
    tick(1);
    rx_done_clear_in = 2'h0;
    rx(ID_A, 1'b1);
    `CHK("ext vs std", 2'h0, receive_done_flag_out)
    receive_mode_field_in = 4'h1;
    rx(ID_A, 1'b1);
    `CHK("mode ext", 2'h1, receive_done_flag_out)
    receive_mode_field_in = 4'h5;
    rx(ID_B | 29'h1, 1'b1);
    `CHK("mask", 2'h3, receive_done_flag_out)
    overrun_clear_in = 2'h3;
    tick(1);
    overrun_clear_in = 2'h0;
    rx(ID_B | 29'h1, 1'b1);
    `CHK("overrun one", 3'h5, {receive_overrun_flag_out, err_irq_out})
    $display("test filter ended");
    receive_mode_field_in = 4'h0;
    err(96);
    `CHK("rx count", 8'h60, receive_error_counter_out)
    `CHK("rx warn", 2'h3, {receive_warning_flag_out, invalid_message_flag_out})
    err(32);
    `CHK("rx passive", 1'b1, receive_passive_flag_out)
    init_mode_in = 1'b1;
    tick(2);
    init_mode_in = 1'b0;
    `CHK("init", 9'h001, {receive_error_counter_out, invalid_message_flag_out})
    $display("test errors ended");
    error_clear_in = 1'b1;
    tx_write_in = 1'b1;
    tx_write_sel_in = 2'h1;
    tx_write_data_in = {14{8'h5a}};
    tick(1);
    error_clear_in = 1'b0;
    tx_write_in = 1'b0;
    request_set_in = 3'h7;
    tick(1);
    request_set_in = 3'h0;
    `CHK("queued", 3'h7, transmit_request_bit_out)
    tick(1);
    `CHK("first", 2'h1, tx_sel_out)
    `CHK("image", {14{8'h5a}}, tx_data_out)
    `WT(transmit_buffer_free_flag_out[1])
    `CHK("sent", 4'hd, {tx_irq_out, transmit_request_bit_out})
    result = 2'h1;
    `WT(arbitration_lost_flag_out[2])
    `CHK("arb kept", 1'b1, transmit_request_bit_out[2])
    request_clear_in = 3'h4;
    tick(1);
    request_clear_in = 3'h0;
    `WT(transmit_aborted_flag_out[2])
    `CHK("abort", 2'h0, {transmit_request_bit_out[2],
      transmit_buffer_free_flag_out[2]})
    request_set_in = 3'h4;
    tick(1);
    request_set_in = 3'h0;
    `CHK("cleared", 2'h0, {transmit_aborted_flag_out[2],
      arbitration_lost_flag_out[2]})
    abort_all_bit_in = 1'b1;
    tick(1);
    abort_all_bit_in = 1'b0;
    `WT(transmit_request_bit_out == 3'h0)
    `CHK("abort all", 3'h5, transmit_aborted_flag_out)
    result = 2'h2;
    request_set_in = 3'h1;
    tick(1);
    request_set_in = 3'h0;
    `WT(transmit_error_counter_out == 9'h061)
    tick(2);
    `CHK("tx warn", 3'h7, {transmit_warning_flag_out, summary_error_flag_out,
      transmit_error_flag_out[0]})
    `WT(transmit_error_counter_out == 9'h080)
    tick(2);
    `CHK("tx passive", 1'b1, transmit_passive_flag_out)
    `WT(transmit_error_counter_out == 9'h100)
    tick(2);
    `CHK("bus off", 2'h2, {bus_off_flag_out, tx_pending_out})
    $display("test transmit ended");
    conclude();
  end
endmodule
